/* File: pkg/dmx_pkg.sv */
// shared constants and types for the data-move execution block
// assumes a single-clock core; decoder supplies one operation per valid cycle
package dmx_pkg;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic       TGT_ACC  = 1'b0;
  localparam logic       TGT_FILE = 1'b1;
  typedef enum logic [1:0] {
    DMX_IDLE,
    DMX_COPY,
    DMX_STORE,
    DMX_LOAD
  } dmx_op_t;
endpackage

/* File: rtl/dmx_file_mem.sv */
// file register space: 128 bytes, one write port, one registered read port
// assumes caller presents address one cycle before it needs the data
`timescale 1ns/1ps
module dmx_file_mem #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // storage has no reset so it can map onto ram
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // registered read, write-first not needed: reads address ahead
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

/* File: rtl/dmx_exec.sv */
// execution of copy, store, load-literal and idle operations
// assumes the decoder holds op fields one cycle earlier on pre_* ports for
// the file read, then pulses op_valid with the fields for execution
`timescale 1ns/1ps
module dmx_exec
  import dmx_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  input  wire logic [dmx_pkg::ADDR_W-1:0] pre_reg_index,
  input  wire logic                       op_valid,
  input  wire dmx_pkg::dmx_op_t           op_code,
  input  wire logic                       target_choice,
  input  wire logic [dmx_pkg::ADDR_W-1:0] reg_index,
  input  wire logic [dmx_pkg::DATA_W-1:0] literal_value,
  output logic      [dmx_pkg::DATA_W-1:0] acc_reg,
  output logic                            null_result_bit,
  output logic                            file_wr_reg,
  output logic      [dmx_pkg::ADDR_W-1:0] file_wr_addr_reg,
  output logic      [dmx_pkg::DATA_W-1:0] file_wr_data_reg,
  output logic                            done_reg
);
  import dmx_pkg::*;

  // ------------------------------------------------------------
  // file space
  // ------------------------------------------------------------
  logic [DATA_W-1:0] file_rd_data;
  logic              mem_we;
  logic [DATA_W-1:0] mem_wd;

  dmx_file_mem #(
    .DW (DATA_W),
    .AW (ADDR_W)
  ) u_mem (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wr_en   (mem_we),
    .wr_addr (reg_index),
    .wr_data (mem_wd),
    .rd_addr (pre_reg_index),
    .rd_data (file_rd_data)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // one-hot decode of the presented operation; idle decodes to nothing
  wire is_copy  = op_valid && (op_code == DMX_COPY);
  wire is_store = op_valid && (op_code == DMX_STORE);
  wire is_load  = op_valid && (op_code == DMX_LOAD);
  wire copy_to_acc  = is_copy && (target_choice == TGT_ACC);
  wire copy_to_file = is_copy && (target_choice == TGT_FILE);
  // write-back of copy rewrites the same value; kept as a real write so
  // side effects of a file write stay visible to the core
  assign mem_we = copy_to_file || is_store;
  assign mem_wd = is_store ? acc_reg : file_rd_data;

  wire [DATA_W-1:0] acc_next =
    copy_to_acc ? file_rd_data :
    is_load     ? literal_value : acc_reg;
  wire z_next = is_copy ? (file_rd_data == ZERO_BYTE)
                        : null_result_bit;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // accumulator and zero flag; single-cycle update per operation
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg         <= ACC_RESET;
      null_result_bit <= 1'b0;
    end else begin
      acc_reg         <= acc_next;
      null_result_bit <= z_next;
    end
  end

  // mirrored write strobe so the rest of the core sees file updates
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      file_wr_reg      <= 1'b0;
      file_wr_addr_reg <= '0;
      file_wr_data_reg <= FILE_RESET;
      done_reg         <= 1'b0;
    end else begin
      file_wr_reg      <= mem_we;
      file_wr_addr_reg <= reg_index;
      file_wr_data_reg <= mem_wd;
      done_reg         <= op_valid;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_copy_acc_load: assert property (copy_to_acc |=> acc_reg == $past(file_rd_data))
    else $error("copy to accumulator wrong");
  a_copy_file_keep: assert property (copy_to_file |=> $stable(acc_reg) && file_wr_reg)
    else $error("copy to file altered accumulator");
  a_copy_wb_data: assert property (copy_to_file |=> file_wr_data_reg == $past(file_rd_data))
    else $error("copy write-back data wrong");
  a_copy_zero_flag: assert property (is_copy |=> null_result_bit == ($past(file_rd_data) == 8'h00))
    else $error("zero flag wrong after copy");
  a_store_data: assert property (is_store |=> file_wr_reg && file_wr_data_reg == $past(acc_reg))
    else $error("store data wrong");
  a_store_flags: assert property (is_store |=> $stable(null_result_bit) && $stable(acc_reg))
    else $error("store altered state");
  a_load_literal: assert property (is_load |=> acc_reg == $past(literal_value) && $stable(null_result_bit))
    else $error("load literal wrong");
  a_idle_quiet: assert property ((!op_valid || op_code == DMX_IDLE) |=> $stable(acc_reg) && $stable(null_result_bit) && !file_wr_reg)
    else $error("idle changed state");
  a_one_cycle: assert property (op_valid |=> done_reg)
    else $error("operation not done in one cycle");

  c_copy_zero: cover property (is_copy ##1 null_result_bit);
  c_copy_file: cover property (copy_to_file);
  c_store_then_copy: cover property (is_store ##1 is_copy);
  c_load: cover property (is_load);
endmodule

/* File: tb/tb_dmx_exec.sv */
// self-checking bench for the data-move execution block
// assumes the block holds its own file space and answers one cycle after op_valid
`timescale 1ns/1ps
module tb_dmx_exec;
  import dmx_pkg::*;
  typedef struct {dmx_op_t op; logic tg; logic [6:0] ix; logic [7:0] lit, acc; logic z, wr;
    logic [7:0] wd;} dmx_row_t;
  logic       clk_sys = 0, rst_b = 0, op_valid = 0, target_choice = 0;
  logic       null_result_bit, file_wr_reg, done_reg;
  logic [6:0] pre_reg_index = 0, reg_index = 0, file_wr_addr_reg;
  logic [7:0] literal_value = 0, acc_reg, file_wr_data_reg;
  dmx_op_t    op_code = DMX_IDLE;
  int         n_fail = 0, num_checks = 0, cyc = 0;
  // each row: op, target, index, literal, then expected acc, flag, write, write data
  dmx_row_t rows [10] = '{
    '{DMX_LOAD, 0, 7'h00, 8'h5A, 8'h5A, 0, 0, 8'h00},
    '{DMX_STORE, 0, 7'h7F, 8'h00, 8'h5A, 0, 1, 8'h5A},
    '{DMX_LOAD, 0, 7'h00, 8'h00, 8'h00, 0, 0, 8'h00},
    '{DMX_STORE, 0, 7'h00, 8'h00, 8'h00, 0, 1, 8'h00},
    '{DMX_COPY, 0, 7'h7F, 8'h00, 8'h5A, 0, 0, 8'h00},
    '{DMX_COPY, 1, 7'h00, 8'h00, 8'h5A, 1, 1, 8'h00},
    '{DMX_STORE, 0, 7'h05, 8'h00, 8'h5A, 1, 1, 8'h5A},
    '{DMX_IDLE, 0, 7'h05, 8'h00, 8'h5A, 1, 0, 8'h00},
    '{DMX_COPY, 0, 7'h05, 8'h00, 8'h5A, 0, 0, 8'h00},
    '{DMX_LOAD, 1, 7'h00, 8'hFF, 8'hFF, 0, 0, 8'h00}};

  dmx_exec i_dmx_exec (.clk_sys(clk_sys), .rst_b(rst_b), .pre_reg_index(pre_reg_index),
    .op_valid(op_valid), .op_code(op_code), .target_choice(target_choice),
    .reg_index(reg_index), .literal_value(literal_value), .acc_reg(acc_reg),
    .null_result_bit(null_result_bit), .file_wr_reg(file_wr_reg),
    .file_wr_addr_reg(file_wr_addr_reg), .file_wr_data_reg(file_wr_data_reg),
    .done_reg(done_reg));

  always #5 clk_sys = ~clk_sys;
  // a hang is cut short well past the few dozen cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 400) begin
      n_fail++;
      complete_run();
    end
  end

  task complete_run;
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // address goes out a cycle ahead so the file read is ready at the op edge
  task run(input dmx_row_t r);
    @(posedge clk_sys) #1 pre_reg_index = r.ix;
    @(posedge clk_sys) #1 op_valid = 1;
    op_code = r.op;
    target_choice = r.tg;
    reg_index = r.ix;
    literal_value = r.lit;
    @(posedge clk_sys) #1 op_valid = 0;
  endtask

  // write address and data only matter while the write pulse is up
  function automatic logic [31:0] obs();
    return {6'h0, acc_reg, null_result_bit, file_wr_reg, done_reg,
      file_wr_reg ? {file_wr_addr_reg, file_wr_data_reg} : 15'h0};
  endfunction

  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_b = 1;
    foreach (rows[i]) begin
      run(rows[i]);
      chk(obs(), {6'h0, rows[i].acc, rows[i].z, rows[i].wr, 1'b1,
        rows[i].wr ? {rows[i].ix, rows[i].wd} : 15'h0});
    end
    // back-to-back loads: one result per cycle, done drops one cycle after op_valid falls
    @(posedge clk_sys) #1 op_valid = 1;
    op_code = DMX_LOAD;
    literal_value = 8'h00;
    @(posedge clk_sys) #1 literal_value = 8'h3C;
    chk(acc_reg, 8'h00);
    @(posedge clk_sys) #1 op_valid = 0;
    chk({acc_reg, null_result_bit, done_reg}, {8'h3C, 2'b01});
    @(posedge clk_sys) #1 chk(done_reg, 0);
    // reset in mid-run clears accumulator, flag and pulses at once
    rst_b = 0;
    #1 chk({acc_reg, null_result_bit, file_wr_reg, done_reg}, 0);
    // second release: ops work again and unreset file space keeps its bytes
    @(posedge clk_sys) #1 rst_b = 1;
    run('{DMX_LOAD, 0, 7'h00, 8'h81, 8'h81, 0, 0, 8'h00});
    chk({acc_reg, null_result_bit, done_reg}, {8'h81, 2'b01});
    run('{DMX_COPY, 0, 7'h7F, 8'h00, 8'h5A, 0, 0, 8'h00});
    chk({acc_reg, null_result_bit, file_wr_reg}, {8'h5A, 2'b00});
    complete_run();
  end
endmodule
